/* dsm_pkg.sv */
package dsm_pkg;

   // ------------------------------------------------------------
   // register map (byte offsets)
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_TASKS = 8'h00;
   localparam logic [7:0] OFF_EVENTS = 8'h04;
   localparam logic [7:0] OFF_MASK = 8'h08;
   localparam logic [7:0] OFF_ENABLE = 8'h0C;
   localparam logic [7:0] OFF_CONFIG = 8'h10;
   localparam logic [7:0] OFF_DIVIDER = 8'h14;
   localparam logic [7:0] OFF_FILL = 8'h18;
   localparam logic [7:0] OFF_TX_PTR = 8'h1C;
   localparam logic [7:0] OFF_TX_CNT = 8'h20;
   localparam logic [7:0] OFF_RX_PTR = 8'h24;
   localparam logic [7:0] OFF_RX_CNT = 8'h28;
   localparam logic [7:0] OFF_STATUS = 8'h2C;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int TASK_START = 0;
   localparam int TASK_STOP = 1;
   localparam int TASK_SUSPEND = 2;
   localparam int TASK_RESUME = 3;
   localparam int EV_STARTED = 0;
   localparam int EV_TX_DONE = 1;
   localparam int EV_RX_DONE = 2;
   localparam int EV_END = 3;
   localparam int EV_HALTED = 4;
   localparam int EV_SUSPENDED = 5;
   localparam int EV_W = 6;
   localparam int CFG_LSB_FIRST = 0;
   localparam int CFG_CPHA = 1;
   localparam int CFG_CPOL = 2;
   localparam int STAT_BUSY = 16;
   localparam int STAT_SUSP = 17;
   localparam int CNT_W = 16;

   // ------------------------------------------------------------
   // reset values and timing
   // ------------------------------------------------------------
   localparam logic [7:0] DIVIDER_RESET = 8'h1F;
   localparam logic [7:0] FILL_RESET = 8'h00;
   localparam int CLOCK_PERIOD_PS = 4000;
   localparam int SCK_MIN_PERIOD_NS = 125;
   localparam int SCK_MIN_HALF_CYC =
      (SCK_MIN_PERIOD_NS * 1000 / 2 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
   localparam logic [7:0] MIN_HALF_RELOAD = 8'(SCK_MIN_HALF_CYC - 1);

   typedef struct packed {
      logic cpol;
      logic cpha;
      logic lsb_first;
   } dsm_cfg_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_NEXT, ST_FETCH, ST_SHIFT, ST_WAIT, ST_STORE, ST_SUSP
   } dsm_state_t;

endpackage

/* dsm_byte_shifter.sv */
module dsm_byte_shifter
   import dsm_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic start,
   input wire logic [7:0] tx_byte,
   input wire dsm_cfg_t cfg,
   input wire logic [7:0] half_reload,
   input wire logic miso_sync,
   output logic sck,
   output logic mosi,
   output logic busy,
   output logic done,
   output logic [7:0] rx_byte
);

   logic [7:0] div_cnt;
   logic [3:0] edge_cnt;
   logic [7:0] tx_sr;
   logic [7:0] rx_sr;

   function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                           input logic lsb);
      return lsb ? {b, v[7:1]} : {v[6:0], b};
   endfunction

   wire tick = busy && (div_cnt == 8'h00);
   wire leading = ~edge_cnt[0];
   // sample on leading edge in phase 0, on trailing edge in phase 1
   wire sample_edge = leading ^ cfg.cpha;
   wire last_edge = (edge_cnt == 4'hF);
   wire cur_bit = cfg.lsb_first ? tx_sr[0] : tx_sr[7];
   wire nxt_bit = cfg.lsb_first ? tx_sr[1] : tx_sr[6];
   wire first_bit = cfg.lsb_first ? tx_byte[0] : tx_byte[7];
   wire [7:0] next_rx = shift_in(rx_sr, miso_sync, cfg.lsb_first);
   wire [7:0] next_tx = shift_in(tx_sr, 1'b0, cfg.lsb_first);

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sck <= 1'b0;
         mosi <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         rx_byte <= 8'h00;
         div_cnt <= 8'h00;
         edge_cnt <= 4'h0;
         tx_sr <= 8'h00;
         rx_sr <= 8'h00;
      end else begin
         done <= 1'b0;
         if (!busy) begin
            sck <= cfg.cpol;
            if (start) begin
               busy <= 1'b1;
               tx_sr <= tx_byte;
               div_cnt <= half_reload;
               edge_cnt <= 4'h0;
               if (!cfg.cpha) begin
                  mosi <= first_bit;
               end
            end
         end else if (!tick) begin
            div_cnt <= div_cnt - 8'h01;
         end else begin
            div_cnt <= half_reload;
            sck <= ~sck;
            edge_cnt <= edge_cnt + 4'h1;
            if (sample_edge) begin
               rx_sr <= next_rx;
            end else begin
               tx_sr <= next_tx;
               if (cfg.cpha) begin
                  mosi <= cur_bit;
               end else if (!last_edge) begin
                  mosi <= nxt_bit;
               end
            end
            if (last_edge) begin
               busy <= 1'b0;
               done <= 1'b1;
               rx_byte <= sample_edge ? next_rx : rx_sr;
            end
         end
      end
   end

endmodule

/* dsm_dma_serial_master.sv */
// Contract
// - start task begins a transaction shifting MOSI out while capturing MISO.
// - raise tx-done once the programmed transmit byte count has been sent.
// - raise rx-done once the programmed receive byte count has been stored.
// - end the transaction by itself once all bytes are handled.
// - send the fill character for bytes beyond the transmit count.
// - raise combined-done only after both tx-done and rx-done.
// - stop task finishes the byte in progress then ceases shifting.
// - raise halted once actually at rest after a stop.
// - raise tx-done at the stop if not raised yet.
// - raise rx-done at the stop if not raised yet.
// - suspend pauses the transaction; resume continues it where it paused.
// - suspend completes the current byte before entering the suspended state.
// - received bytes beyond the receive count are clocked but dropped.
// - pointers and counts are double-buffered, reloadable after started.
// - all four clock modes from polarity and phase settings.
//
// Local design decisions: the address map and register access over Avalon-MM.
module dsm_dma_serial_master
   import dsm_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   output logic mem_rd_req,
   output logic [31:0] mem_rd_addr,
   input wire logic mem_rd_ack,
   input wire logic [7:0] mem_rd_data,
   output logic mem_wr_req,
   output logic [31:0] mem_wr_addr,
   output logic [7:0] mem_wr_data,
   input wire logic mem_wr_ack,
   output logic sck,
   output logic mosi,
   input wire logic miso
);

   // ------------------------------------------------------------
   // software-visible registers
   // ------------------------------------------------------------
   logic [EV_W-1:0] events;
   logic [EV_W-1:0] mask;
   logic enable;
   dsm_cfg_t cfg;
   logic [7:0] divider;
   logic [7:0] fill_character;
   logic [31:0] tx_buffer_pointer;
   logic [CNT_W-1:0] tx_byte_count;
   logic [31:0] rx_buffer_pointer;
   logic [CNT_W-1:0] rx_byte_count;

   // ------------------------------------------------------------
   // sequencer state
   // ------------------------------------------------------------
   dsm_state_t state;
   logic [31:0] w_tx_ptr;
   logic [31:0] w_rx_ptr;
   logic [CNT_W-1:0] w_tx_cnt;
   logic [CNT_W-1:0] w_rx_cnt;
   logic [CNT_W-1:0] pos;
   logic [7:0] out_byte;
   logic shift_go;
   logic stop_pend;
   logic susp_pend;
   logic tx_fin;
   logic rx_fin;
   logic end_sent;
   logic [EV_W-1:0] ev_pulse;
   logic miso_meta;
   logic miso_sync;

   wire sh_busy;
   wire sh_done;
   wire [7:0] sh_rx;
   wire sh_sck;
   wire sh_mosi;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   wire wr_acc = avs_write & ~avs_waitrequest;
   wire [3:0] task_bits = (wr_acc && hit(avs_address, OFF_TASKS)) ?
                          avs_writedata[3:0] : 4'h0;
   wire task_start = task_bits[TASK_START];
   wire task_stop = task_bits[TASK_STOP];
   wire task_susp = task_bits[TASK_SUSPEND];
   wire task_resume = task_bits[TASK_RESUME];
   wire [EV_W-1:0] ev_clear = (wr_acc && hit(avs_address, OFF_EVENTS)) ?
                              avs_writedata[EV_W-1:0] : '0;
   wire [31:0] status_word = {14'h0000, state == ST_SUSP,
                              state != ST_IDLE, pos};
   wire [31:0] rd_word =
      hit(avs_address, OFF_EVENTS) ? {26'h000_0000, events} :
      hit(avs_address, OFF_MASK) ? {26'h000_0000, mask} :
      hit(avs_address, OFF_ENABLE) ? {31'h0000_0000, enable} :
      hit(avs_address, OFF_CONFIG) ? {29'h0000_0000, cfg} :
      hit(avs_address, OFF_DIVIDER) ? {24'h00_0000, divider} :
      hit(avs_address, OFF_FILL) ? {24'h00_0000, fill_character} :
      hit(avs_address, OFF_TX_PTR) ? tx_buffer_pointer :
      hit(avs_address, OFF_TX_CNT) ? {16'h0000, tx_byte_count} :
      hit(avs_address, OFF_RX_PTR) ? rx_buffer_pointer :
      hit(avs_address, OFF_RX_CNT) ? {16'h0000, rx_byte_count} :
      hit(avs_address, OFF_STATUS) ? status_word : 32'h0000_0000;

   // one wait cycle per access; write lands on the edge waitrequest is low
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else if ((avs_read | avs_write) && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
         avs_readdata <= rd_word;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // live copies are free to change while a transaction runs
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         mask <= '0;
         enable <= 1'b0;
         cfg <= '0;
         divider <= DIVIDER_RESET;
         fill_character <= FILL_RESET;
         tx_buffer_pointer <= 32'h0000_0000;
         tx_byte_count <= 16'h0000;
         rx_buffer_pointer <= 32'h0000_0000;
         rx_byte_count <= 16'h0000;
      end else if (wr_acc) begin
         if (hit(avs_address, OFF_MASK)) mask <= avs_writedata[EV_W-1:0];
         if (hit(avs_address, OFF_ENABLE)) enable <= avs_writedata[0];
         if (hit(avs_address, OFF_CONFIG)) cfg <= avs_writedata[2:0];
         if (hit(avs_address, OFF_DIVIDER)) divider <= avs_writedata[7:0];
         if (hit(avs_address, OFF_FILL)) fill_character <= avs_writedata[7:0];
         if (hit(avs_address, OFF_TX_PTR)) tx_buffer_pointer <= avs_writedata;
         if (hit(avs_address, OFF_TX_CNT)) tx_byte_count <= avs_writedata[15:0];
         if (hit(avs_address, OFF_RX_PTR)) rx_buffer_pointer <= avs_writedata;
         if (hit(avs_address, OFF_RX_CNT)) rx_byte_count <= avs_writedata[15:0];
      end
   end

   // ------------------------------------------------------------
   // events and interrupt
   // ------------------------------------------------------------
   // a new event in the clear cycle survives
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         events <= '0;
         irq <= 1'b0;
      end else begin
         events <= (events & ~ev_clear) | ev_pulse;
         irq <= |(events & mask);
      end
   end

   // ------------------------------------------------------------
   // serial pins
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         miso_meta <= 1'b0;
         miso_sync <= 1'b0;
      end else begin
         miso_meta <= miso;
         miso_sync <= miso_meta;
      end
   end

   // never faster than the minimum serial clock period
   wire [7:0] half_reload = (divider < MIN_HALF_RELOAD) ?
                            MIN_HALF_RELOAD : divider;

   dsm_byte_shifter u_shifter (
      .clock(clock),
      .reset_n(reset_n),
      .start(shift_go),
      .tx_byte(out_byte),
      .cfg(cfg),
      .half_reload(half_reload),
      .miso_sync(miso_sync),
      .sck(sh_sck),
      .mosi(sh_mosi),
      .busy(sh_busy),
      .done(sh_done),
      .rx_byte(sh_rx)
   );

   assign sck = sh_sck;
   assign mosi = sh_mosi;

   // ------------------------------------------------------------
   // transaction sequencer
   // ------------------------------------------------------------
   wire [CNT_W-1:0] total = (w_tx_cnt > w_rx_cnt) ? w_tx_cnt : w_rx_cnt;
   wire all_clocked = (pos == total);
   wire tx_sent = (pos >= w_tx_cnt);
   wire rx_stored = (pos >= w_rx_cnt);
   wire need_fetch = (pos < w_tx_cnt);
   wire need_store = (pos < w_rx_cnt);
   wire running = (state != ST_IDLE);

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         w_tx_ptr <= 32'h0000_0000;
         w_rx_ptr <= 32'h0000_0000;
         w_tx_cnt <= 16'h0000;
         w_rx_cnt <= 16'h0000;
         pos <= 16'h0000;
         out_byte <= 8'h00;
         shift_go <= 1'b0;
         stop_pend <= 1'b0;
         susp_pend <= 1'b0;
         tx_fin <= 1'b0;
         rx_fin <= 1'b0;
         end_sent <= 1'b1;
         ev_pulse <= '0;
         mem_rd_req <= 1'b0;
         mem_rd_addr <= 32'h0000_0000;
         mem_wr_req <= 1'b0;
         mem_wr_addr <= 32'h0000_0000;
         mem_wr_data <= 8'h00;
      end else begin
         ev_pulse <= '0;
         shift_go <= 1'b0;
         if (task_stop && running) stop_pend <= 1'b1;
         if (task_susp && running && state != ST_SUSP) susp_pend <= 1'b1;
         if (tx_fin && rx_fin && !end_sent) begin
            end_sent <= 1'b1;
            ev_pulse[EV_END] <= 1'b1;
         end
         case (state)
            ST_IDLE: begin
               if (task_stop) begin
                  ev_pulse[EV_HALTED] <= 1'b1;
               end else if (task_start && enable) begin
                  w_tx_ptr <= tx_buffer_pointer;
                  w_rx_ptr <= rx_buffer_pointer;
                  w_tx_cnt <= tx_byte_count;
                  w_rx_cnt <= rx_byte_count;
                  pos <= 16'h0000;
                  tx_fin <= 1'b0;
                  rx_fin <= 1'b0;
                  end_sent <= 1'b0;
                  stop_pend <= 1'b0;
                  susp_pend <= 1'b0;
                  ev_pulse[EV_STARTED] <= 1'b1;
                  state <= ST_NEXT;
               end
            end
            ST_NEXT: begin
               if (!tx_fin && (tx_sent || stop_pend)) begin
                  tx_fin <= 1'b1;
                  ev_pulse[EV_TX_DONE] <= 1'b1;
               end
               if (!rx_fin && (rx_stored || stop_pend)) begin
                  rx_fin <= 1'b1;
                  ev_pulse[EV_RX_DONE] <= 1'b1;
               end
               if (stop_pend) begin
                  stop_pend <= 1'b0;
                  susp_pend <= 1'b0;
                  ev_pulse[EV_HALTED] <= 1'b1;
                  state <= ST_IDLE;
               end else if (all_clocked) begin
                  state <= ST_IDLE;
               end else if (susp_pend) begin
                  susp_pend <= 1'b0;
                  ev_pulse[EV_SUSPENDED] <= 1'b1;
                  state <= ST_SUSP;
               end else if (need_fetch) begin
                  mem_rd_req <= 1'b1;
                  mem_rd_addr <= w_tx_ptr + {16'h0000, pos};
                  state <= ST_FETCH;
               end else begin
                  out_byte <= fill_character;
                  shift_go <= 1'b1;
                  state <= ST_SHIFT;
               end
            end
            ST_FETCH: begin
               if (mem_rd_ack) begin
                  mem_rd_req <= 1'b0;
                  out_byte <= mem_rd_data;
                  shift_go <= 1'b1;
                  state <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               state <= ST_WAIT;
            end
            ST_WAIT: begin
               if (sh_done) begin
                  if (need_store) begin
                     mem_wr_req <= 1'b1;
                     mem_wr_addr <= w_rx_ptr + {16'h0000, pos};
                     mem_wr_data <= sh_rx;
                     state <= ST_STORE;
                  end else begin
                     pos <= pos + 16'h0001;
                     state <= ST_NEXT;
                  end
               end
            end
            ST_STORE: begin
               if (mem_wr_ack) begin
                  mem_wr_req <= 1'b0;
                  pos <= pos + 16'h0001;
                  state <= ST_NEXT;
               end
            end
            ST_SUSP: begin
               if (task_stop || task_resume) begin
                  state <= ST_NEXT;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

endmodule

/* dsm_dma_serial_master_checker.sv */
module dsm_dma_serial_master_checker
   import dsm_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic irq,
   input wire logic mem_rd_req,
   input wire logic [31:0] mem_rd_addr,
   input wire logic mem_rd_ack,
   input wire logic mem_wr_req,
   input wire logic [31:0] mem_wr_addr,
   input wire logic [7:0] mem_wr_data,
   input wire logic mem_wr_ack,
   input wire logic sck
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   logic sck_q;
   logic [4:0] gap;
   // saturating count of cycles since sck last moved
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sck_q <= 1'b0;
         gap <= 5'h1F;
      end else begin
         sck_q <= sck;
         gap <= (sck != sck_q) ? 5'h00 : ((gap == 5'h1F) ? gap : gap + 5'h01);
      end
   end
   property p_wait_one;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("long answer");
   property p_wait_answer;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait_answer: assert property (p_wait_answer) else $error("no answer");
   property p_wait_idle;
      !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wait_idle: assert property (p_wait_idle) else $error("stray answer");
   property p_rd_hold;
      mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("fetch dropped");
   property p_rd_drop;
      mem_rd_req && mem_rd_ack |=> !mem_rd_req;
   endproperty
   a_rd_drop: assert property (p_rd_drop) else $error("fetch held after ack");
   property p_rd_gap;
      $fell(mem_rd_req) |=> !mem_rd_req [*8];
   endproperty
   a_rd_gap: assert property (p_rd_gap) else $error("early fetch");
   property p_wr_hold;
      mem_wr_req && !mem_wr_ack |=> mem_wr_req && $stable(mem_wr_addr) && $stable(mem_wr_data);
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("store changed");
   property p_wr_drop;
      mem_wr_req && mem_wr_ack |=> !mem_wr_req;
   endproperty
   a_wr_drop: assert property (p_wr_drop) else $error("store held after ack");
   property p_sck_half;
      (sck != sck_q) |-> gap >= 5'h0F;
   endproperty
   a_sck_half: assert property (p_sck_half) else $error("sck too fast");
   c_store: cover property (mem_wr_req && mem_wr_ack);
   c_irq: cover property ($rose(irq));
   c_sck: cover property (sck != sck_q);
endmodule

bind dsm_dma_serial_master dsm_dma_serial_master_checker i_chk (.clock(clock),
   .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write), .irq(irq),
   .avs_waitrequest(avs_waitrequest), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
   .mem_rd_ack(mem_rd_ack), .mem_wr_req(mem_wr_req), .mem_wr_addr(mem_wr_addr),
   .mem_wr_data(mem_wr_data), .mem_wr_ack(mem_wr_ack), .sck(sck));

/* dsm_spi_slave_model.sv */
module dsm_spi_slave_model
   import dsm_pkg::*;
(
   input wire logic clock,
   input wire logic clear,
   input wire dsm_cfg_t cfg,
   input wire logic sck,
   input wire logic mosi,
   output logic miso
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sck_q;
   logic [3:0] edge_n;
   logic [7:0] shreg;
   logic [7:0] got [0:15];
   int nb;
   wire logic [2:0] bit_k = cfg.lsb_first ? edge_n[3:1] : 3'(3'h7 - edge_n[3:1]);
   wire logic [7:0] reply = 8'(8'h3C + nb * 8'h25);
   wire logic sample = cfg.cpha ? edge_n[0] : !edge_n[0];
   // late phase leaves the line undriven between bits: show a moving level
   assign miso = (cfg.cpha && !edge_n[0]) ? ~reply[bit_k] : reply[bit_k];
   always @(posedge clock) begin
      logic [7:0] nx;
      nx = shreg;
      nx[bit_k] = mosi;
      sck_q <= sck;
      if (clear) begin
         edge_n <= 4'h0;
         nb <= 0;
      end else if (sck !== sck_q) begin
         edge_n <= edge_n + 4'h1;
         if (sample) shreg <= nx;
         if (edge_n == 4'hF) begin
            got[nb] <= cfg.cpha ? nx : shreg;
            nb <= nb + 1;
         end
      end
   end
endmodule

/* dsm_dma_serial_master_bench.sv */
module dsm_dma_serial_master_bench
   import dsm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, reset_n, avs_read, avs_write, avs_waitrequest, irq, clear;
   logic mem_rd_req, mem_rd_ack, mem_wr_req, mem_wr_ack, sck, mosi, miso;
   logic [7:0] avs_address, mem_rd_data, mem_wr_data;
   logic [31:0] avs_writedata, avs_readdata, mem_rd_addr, mem_wr_addr, q;
   logic [31:0] wq_a [$];
   logic [7:0] wq_d [$];
   dsm_cfg_t mcfg;
   int n_errors, tests_run, lat, rlat;
   dsm_dma_serial_master i_dut (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
      .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack),
      .mem_rd_data(mem_rd_data), .mem_wr_req(mem_wr_req), .mem_wr_addr(mem_wr_addr),
      .mem_wr_data(mem_wr_data), .mem_wr_ack(mem_wr_ack), .sck(sck), .mosi(mosi), .miso(miso));
   dsm_spi_slave_model i_slave (.clock(clock), .clear(clear), .cfg(mcfg), .sck(sck),
      .mosi(mosi), .miso(miso));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   function automatic logic [7:0] mem_byte(input logic [31:0] a);
      return a[7:0] ^ 8'h5A;
   endfunction
   function automatic logic [7:0] reply(input int i);
      return 8'(8'h3C + i * 8'h25);
   endfunction
   // ----
   // memory behind both channels; read data line moves while idle
   // ----
   always @(posedge clock) begin
      mem_rd_ack <= 1'b0;
      mem_wr_ack <= 1'b0;
      if (mem_rd_req && !mem_rd_ack && rlat >= lat) begin
         mem_rd_ack <= 1'b1;
         mem_rd_data <= mem_byte(mem_rd_addr);
         rlat <= 0;
      end else begin
         mem_rd_data <= ~mem_rd_data;
         rlat <= mem_rd_req ? rlat + 1 : 0;
      end
      if (mem_wr_req && !mem_wr_ack) begin
         mem_wr_ack <= 1'b1;
         wq_a.push_back(mem_wr_addr);
         wq_d.push_back(mem_wr_data);
      end
   end
   task print_verdict;
      if (n_errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic fail;
      n_errors++;
      print_verdict();
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0) fail();
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wait_ev(input int b);
      int n;
      for (n = 0; n < 4000; n++) begin
         bus(1'b0, OFF_EVENTS, 32'h0000_0000);
         if (q[b] === 1'b1) break;
      end
      if (n == 4000) fail();
   endtask
   // wait for the slave to reach edge e of byte b
   task automatic wait_slave(input int b, input int e);
      int n;
      for (n = 0; n < 9000 && !(i_slave.nb == b && i_slave.edge_n == e); n++) @(posedge clock);
      if (n == 9000) fail();
   endtask
   task automatic go;
      bus(1'b1, OFF_EVENTS, 32'hFFFF_FFFF);
      wq_a.delete();
      wq_d.delete();
      clear <= 1'b1;
      @(posedge clock);
      clear <= 1'b0;
      bus(1'b1, OFF_TASKS, 32'h0000_0001);
   endtask
   task automatic launch(input logic [31:0] tp, tn, rp, rn, input bit s = 1);
      bus(1'b1, OFF_TX_PTR, tp);
      bus(1'b1, OFF_TX_CNT, tn);
      bus(1'b1, OFF_RX_PTR, rp);
      bus(1'b1, OFF_RX_CNT, rn);
      if (s) go();
   endtask
   task automatic check_data(input logic [31:0] tp, tn, rp, rn, nclk, fill);
      int nw;
      for (int i = 0; i < nclk; i++) begin
         chk("mosi byte", (i < tn) ? mem_byte(tp + i) : fill, i_slave.got[i]);
      end
      chk("bytes on link", nclk, i_slave.nb);
      nw = (rn < nclk) ? rn : nclk;
      chk("stores", nw, wq_a.size());
      for (int i = 0; i < nw; i++) begin
         chk("store addr", rp + i, wq_a[i]);
         chk("store data", reply(i), wq_d[i]);
      end
      bus(1'b0, OFF_STATUS, 32'h0000_0000);
      chk("bytes clocked", nclk, q[15:0]);
   endtask
   task automatic s_regs;
      bus(1'b0, OFF_DIVIDER, 32'h0000_0000);
      chk("divider reset", DIVIDER_RESET, q);
      bus(1'b0, OFF_FILL, 32'h0000_0000);
      chk("fill reset", FILL_RESET, q);
      bus(1'b1, 8'hF0, 32'hFFFF_FFFF);
      bus(1'b0, 8'hF0, 32'h0000_0000);
      chk("unmapped", 32'h0000_0000, q);
      bus(1'b1, OFF_DIVIDER, 32'h0000_0000);
      bus(1'b1, OFF_FILL, 32'h0000_00A5);
      bus(1'b1, OFF_ENABLE, 32'h0000_0001);
   endtask
   task automatic s_basic;
      launch(32'h0000_0100, 3, 32'h0000_0200, 3);
      wait_ev(EV_STARTED);
      launch(32'h0000_0300, 1, 32'h0000_0400, 2, 0);
      wait_ev(EV_END);
      bus(1'b0, OFF_EVENTS, 32'h0000_0000);
      chk("events", 32'h0000_000F, q);
      check_data(32'h0000_0100, 3, 32'h0000_0200, 3, 3, 8'hA5);
      go();
      wait_ev(EV_END);
      check_data(32'h0000_0300, 1, 32'h0000_0400, 2, 2, 8'hA5);
   endtask
   task automatic s_drop;
      lat = 4;
      launch(32'h0000_0500, 3, 32'h0000_0600, 1);
      wait_ev(EV_END);
      check_data(32'h0000_0500, 3, 32'h0000_0600, 1, 3, 8'hA5);
      lat = 0;
   endtask
   task automatic s_modes;
      for (int m = 0; m < 8; m++) begin
         bus(1'b1, OFF_CONFIG, 32'(m));
         mcfg <= dsm_cfg_t'(m[2:0]);
         launch(32'h0000_0700 + m, 1, 32'h0000_0800, 1);
         wait_ev(EV_END);
         chk("sck idle", m[2], sck);
         check_data(32'h0000_0700 + m, 1, 32'h0000_0800, 1, 1, 8'hA5);
      end
      bus(1'b1, OFF_CONFIG, 32'h0000_0000);
      mcfg <= '0;
   endtask
   task automatic s_stop;
      bus(1'b1, OFF_MASK, 32'h0000_0010);
      launch(32'h0000_0900, 4, 32'h0000_0A00, 4);
      wait_slave(1, 4);
      bus(1'b1, OFF_TASKS, 32'h0000_0002);
      wait_ev(EV_HALTED);
      bus(1'b0, OFF_EVENTS, 32'h0000_0000);
      chk("events", 32'h0000_001F, q);
      chk("irq", 1'b1, irq);
      check_data(32'h0000_0900, 4, 32'h0000_0A00, 4, 2, 8'hA5);
      bus(1'b1, OFF_EVENTS, 32'h0000_0010);
      @(posedge clock);
      chk("irq", 1'b0, irq);
   endtask
   task automatic s_suspend;
      launch(32'h0000_0B00, 3, 32'h0000_0C00, 3);
      wait_slave(0, 6);
      bus(1'b1, OFF_TASKS, 32'h0000_0004);
      wait_ev(EV_SUSPENDED);
      repeat (600) @(posedge clock);
      chk("bytes while held", 1, i_slave.nb);
      bus(1'b0, OFF_STATUS, 32'h0000_0000);
      chk("held flag", 1'b1, q[STAT_SUSP]);
      bus(1'b1, OFF_TASKS, 32'h0000_0008);
      wait_ev(EV_END);
      check_data(32'h0000_0B00, 3, 32'h0000_0C00, 3, 3, 8'hA5);
   endtask
   initial begin
      reset_n = 1'b0;
      {avs_read, avs_write} = 2'h0;
      clear = 1'b1;
      mcfg = '0;
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
      clear <= 1'b0;
      @(posedge clock);
      s_regs();
      s_basic();
      s_drop();
      s_modes();
      s_stop();
      s_suspend();
      print_verdict();
   end
endmodule
